/* hdl/wsic_consts.svh */
// Register offsets, field positions, reset values for the shutdown and input control block
`ifndef WSIC_CONSTS_SVH
`define WSIC_CONSTS_SVH

// ==========================================
// Register byte offsets
`define WSIC_OFS_LVLSEL   5'h00
`define WSIC_OFS_CTRL     5'h04
`define WSIC_OFS_SHDN     5'h08
`define WSIC_OFS_DBAND    5'h0c
`define WSIC_OFS_IRQ_STAT 5'h10
`define WSIC_OFS_IRQ_MASK 5'h14

// ==========================================
// Field positions
`define WSIC_LVLB_HI      7
`define WSIC_LVLB_LO      6
`define WSIC_LVLA_HI      5
`define WSIC_LVLA_LO      4
`define WSIC_INSEL_HI     2
`define WSIC_POLA_BIT     0
`define WSIC_POLB_BIT     1
`define WSIC_FLAG_BIT     7
`define WSIC_ARS_BIT      6
`define WSIC_SRCEN_HI     2
`define WSIC_DB_HI        5
`define WSIC_IRQ_SHDN     0
`define WSIC_IRQ_RESUME   1

// ==========================================
// Reset values
`define WSIC_LVLSEL_RST   8'h00
`define WSIC_POL_RST      2'h0
`define WSIC_SRCEN_RST    3'h0
`define WSIC_DB_RST       6'h00
`define WSIC_IRQ_RST      2'h0

`endif

/* hdl/wsic_pkg.sv */
// Types shared by the shutdown and input control block
package wsic_pkg;
	// ==========================================
	// Shutdown override level, in field order 00..11
	typedef enum logic [1:0] {WSIC_LVL_INACT, WSIC_LVL_TRI, WSIC_LVL_LOW, WSIC_LVL_HIGH} wsic_lvl_t;
	// ==========================================
	// Override sequencing
	typedef enum logic [1:0] {WSIC_RUN, WSIC_SHDN, WSIC_HOLD} wsic_state_t;
endpackage

/* hdl/wsic_ovr_if.sv */
// Override controls passed from the control core to the output stage
`timescale 1ns/1ps
interface wsic_ovr_if;
	import wsic_pkg::*;
	logic      override;
	logic      db_done;
	wsic_lvl_t lvl  [2];
	logic      pol  [2];
	logic      wave [2];
	modport ctrl  (output override, db_done, lvl, pol, wave);
	modport stage (input override, db_done, lvl, pol, wave);
endinterface

/* hdl/wsic_sync.sv */
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module wsic_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         nrst,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// ==========================================
	// Synchroniser chain
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule // wsic_sync

/* hdl/wsic_out_stage.sv */
// Output pin stage: normal waveform or shutdown override per output
`timescale 1ns/1ps
module wsic_out_stage (
	// Clock and reset
	input  wire logic   core_clk,
	input  wire logic   nrst,
	// Controls
	wsic_ovr_if.stage   ovr,
	// Pins, index 0 is output A, index 1 is output B
	output logic [1:0]  pin,
	output logic [1:0]  pin_oe
);
	import wsic_pkg::*;

	// ==========================================
	// Per-output drive
	for (genvar i = 0; i < 2; i++) begin : g_out
		always_ff @(posedge core_clk) begin
			if (!nrst) begin
				pin[i]    <= 1'b0;
				pin_oe[i] <= 1'b0;
			end else if (ovr.override) begin
				unique case (ovr.lvl[i])
					WSIC_LVL_HIGH: begin
						pin[i]    <= 1'b1;
						pin_oe[i] <= 1'b1;
					end
					WSIC_LVL_LOW: begin
						pin[i]    <= 1'b0;
						pin_oe[i] <= 1'b1;
					end
					WSIC_LVL_TRI: begin
						pin[i]    <= 1'b0;
						pin_oe[i] <= 1'b0;
					end
					WSIC_LVL_INACT: begin
						pin_oe[i] <= 1'b1;
						if (ovr.db_done)
							pin[i] <= ovr.pol[i];
					end
				endcase
			end else begin
				pin[i]    <= ovr.wave[i] ^ ovr.pol[i];
				pin_oe[i] <= 1'b1;
			end
		end
	end

	// ==========================================
	// Checks
	b_force_high_a: assert property (@(posedge core_clk) disable iff (!nrst)
		ovr.override && ovr.lvl[1] == WSIC_LVL_HIGH |=> pin[1] && pin_oe[1]) else $error("B not high");
	b_force_low_a: assert property (@(posedge core_clk) disable iff (!nrst)
		ovr.override && ovr.lvl[1] == WSIC_LVL_LOW |=> !pin[1] && pin_oe[1]) else $error("B not low");
	b_tristate_a: assert property (@(posedge core_clk) disable iff (!nrst)
		ovr.override && ovr.lvl[1] == WSIC_LVL_TRI |=> !pin_oe[1]) else $error("B driven");
	b_inactive_a: assert property (@(posedge core_clk) disable iff (!nrst)
		ovr.override && ovr.lvl[1] == WSIC_LVL_INACT && ovr.db_done |=> pin[1] == $past(ovr.pol[1]) && pin_oe[1])
		else $error("B not inactive");
	a_force_high_a: assert property (@(posedge core_clk) disable iff (!nrst)
		ovr.override && ovr.lvl[0] == WSIC_LVL_HIGH |=> pin[0] && pin_oe[0]) else $error("A not high");
	a_force_low_a: assert property (@(posedge core_clk) disable iff (!nrst)
		ovr.override && ovr.lvl[0] == WSIC_LVL_LOW |=> !pin[0] && pin_oe[0]) else $error("A not low");
	a_tristate_a: assert property (@(posedge core_clk) disable iff (!nrst)
		ovr.override && ovr.lvl[0] == WSIC_LVL_TRI |=> !pin_oe[0]) else $error("A driven");
	a_inactive_a: assert property (@(posedge core_clk) disable iff (!nrst)
		ovr.override && ovr.lvl[0] == WSIC_LVL_INACT && !ovr.db_done |=> $stable(pin[0]) && pin_oe[0])
		else $error("A left hold early");
	normal_follow_a: assert property (@(posedge core_clk) disable iff (!nrst)
		!ovr.override |=> pin[0] == $past(ovr.wave[0] ^ ovr.pol[0]) && pin[1] == $past(ovr.wave[1] ^ ovr.pol[1]))
		else $error("Outputs not following waveform");
endmodule // wsic_out_stage

/* hdl/wsic_shutdown_ctrl.sv */
// Shutdown override and input source control with Avalon-MM register access
`timescale 1ns/1ps
`include "wsic_consts.svh"
module wsic_shutdown_ctrl #(
	parameter int N_IN  = 8,
	parameter int N_SRC = 3
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              nrst,
	// Avalon-MM slave
	input  wire logic [4:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	// Waveform input candidates and shutdown sources, asynchronous pins
	input  wire logic [N_IN-1:0]   input_src,
	input  wire logic [N_SRC-1:0]  shutdown_src,
	// Output pins
	output logic                   output_a,
	output logic                   output_a_oe,
	output logic                   output_b,
	output logic                   output_b_oe,
	// Interrupt
	output logic                   irq
);
	import wsic_pkg::*;

	// ==========================================
	// Declarations
	logic [7:0]       lvlsel_reg;
	logic [1:0]       pol_reg;
	logic             flag_reg;
	logic             flag_next;
	logic             ars_reg;
	logic [N_SRC-1:0] srcen_reg;
	logic [5:0]       db_reg;
	logic [5:0]       db_cnt_reg;
	logic [1:0]       irq_stat_reg;
	logic [1:0]       irq_stat_next;
	logic [1:0]       irq_mask_reg;
	logic             ack_reg;
	logic             wr_en;
	logic [N_IN-1:0]  in_sync;
	logic [N_SRC-1:0] src_sync;
	logic             in_sel;
	logic             in_sel_d_reg;
	logic             in_rise;
	logic             src_hit;
	logic [31:0]      rd_mux;
	logic [1:0]       pin;
	logic [1:0]       pin_oe;
	wsic_state_t      state_reg;
	wsic_state_t      state_next;
	wsic_ovr_if       ovr ();

	// ==========================================
	// Pin synchronisers
	wsic_sync #(.W(N_IN)) u_in_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.d        (input_src),
		.q        (in_sync)
	);

	wsic_sync #(.W(N_SRC)) u_src_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.d        (shutdown_src),
		.q        (src_sync)
	);

	// ==========================================
	// Avalon handshake: one wait cycle, then answer
	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
	assign wr_en           = avs_write && ack_reg && avs_byteenable[0];

	always_ff @(posedge core_clk) begin
		if (!nrst)
			ack_reg <= 1'b0;
		else
			ack_reg <= (avs_read || avs_write) && !ack_reg;
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (avs_address)
			`WSIC_OFS_LVLSEL:   rd_mux[7:0] = {lvlsel_reg[7:4], 1'b0, lvlsel_reg[2:0]};
			`WSIC_OFS_CTRL:     rd_mux[1:0] = pol_reg;
			`WSIC_OFS_SHDN:     rd_mux[7:0] = {flag_reg, ars_reg, 3'h0, srcen_reg};
			`WSIC_OFS_DBAND:    rd_mux[5:0] = db_reg;
			`WSIC_OFS_IRQ_STAT: rd_mux[1:0] = irq_stat_reg;
			`WSIC_OFS_IRQ_MASK: rd_mux[1:0] = irq_mask_reg;
			default:            rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!nrst)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && !ack_reg)
			avs_readdata <= rd_mux;
	end

	// ==========================================
	// Configuration registers
	always_ff @(posedge core_clk) begin
		if (!nrst)
			lvlsel_reg <= `WSIC_LVLSEL_RST;
		else if (wr_en && avs_address == `WSIC_OFS_LVLSEL)
			lvlsel_reg <= {avs_writedata[7:4], 1'b0, avs_writedata[2:0]};
	end

	always_ff @(posedge core_clk) begin
		if (!nrst)
			pol_reg <= `WSIC_POL_RST;
		else if (wr_en && avs_address == `WSIC_OFS_CTRL)
			pol_reg <= avs_writedata[1:0];
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ars_reg   <= 1'b0;
			srcen_reg <= `WSIC_SRCEN_RST;
		end else if (wr_en && avs_address == `WSIC_OFS_SHDN) begin
			ars_reg   <= avs_writedata[`WSIC_ARS_BIT];
			srcen_reg <= avs_writedata[N_SRC-1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst)
			db_reg <= `WSIC_DB_RST;
		else if (wr_en && avs_address == `WSIC_OFS_DBAND)
			db_reg <= avs_writedata[`WSIC_DB_HI:0];
	end

	// ==========================================
	// Input source selection and rising edge
	always_comb begin
		if (lvlsel_reg[`WSIC_INSEL_HI:0] == 3'h0)
			in_sel = 1'b0;
		else
			in_sel = in_sync[lvlsel_reg[`WSIC_INSEL_HI:0]];
	end

	always_ff @(posedge core_clk) begin
		if (!nrst)
			in_sel_d_reg <= 1'b0;
		else
			in_sel_d_reg <= in_sel;
	end

	assign in_rise = in_sel && !in_sel_d_reg;

	// ==========================================
	// Shutdown event flag: a present source wins over any clear
	assign src_hit = |(src_sync & srcen_reg);

	always_comb begin
		flag_next = flag_reg;
		if (src_hit)
			flag_next = 1'b1;
		else if (ars_reg)
			flag_next = 1'b0;
		else if (wr_en && avs_address == `WSIC_OFS_SHDN)
			flag_next = avs_writedata[`WSIC_FLAG_BIT];
	end

	always_ff @(posedge core_clk) begin
		if (!nrst)
			flag_reg <= 1'b0;
		else
			flag_reg <= flag_next;
	end

	// ==========================================
	// Override sequencing
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			WSIC_RUN:  if (flag_reg) state_next = WSIC_SHDN;
			WSIC_SHDN: if (!flag_reg) state_next = WSIC_HOLD;
			WSIC_HOLD: begin
				if (flag_reg)
					state_next = WSIC_SHDN;
				else if (in_rise)
					state_next = WSIC_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!nrst)
			state_reg <= WSIC_RUN;
		else
			state_reg <= state_next;
	end

	// ==========================================
	// Dead-band timer on shutdown entry
	always_ff @(posedge core_clk) begin
		if (!nrst)
			db_cnt_reg <= 6'h00;
		else if (state_reg == WSIC_RUN)
			db_cnt_reg <= 6'h00;
		else if (db_cnt_reg < db_reg)
			db_cnt_reg <= db_cnt_reg + 6'h01;
	end

	// ==========================================
	// Interrupt status, write one to clear, set wins
	always_comb begin
		irq_stat_next = irq_stat_reg;
		if (wr_en && avs_address == `WSIC_OFS_IRQ_STAT)
			irq_stat_next = irq_stat_reg & ~avs_writedata[1:0];
		if (state_reg == WSIC_RUN && state_next == WSIC_SHDN)
			irq_stat_next[`WSIC_IRQ_SHDN] = 1'b1;
		if (state_reg == WSIC_HOLD && state_next == WSIC_RUN)
			irq_stat_next[`WSIC_IRQ_RESUME] = 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst)
			irq_stat_reg <= `WSIC_IRQ_RST;
		else
			irq_stat_reg <= irq_stat_next;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst)
			irq_mask_reg <= `WSIC_IRQ_RST;
		else if (wr_en && avs_address == `WSIC_OFS_IRQ_MASK)
			irq_mask_reg <= avs_writedata[1:0];
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	// ==========================================
	// Output stage
	assign ovr.override = state_reg != WSIC_RUN;
	assign ovr.db_done  = db_cnt_reg >= db_reg;
	assign ovr.lvl[0]   = wsic_lvl_t'(lvlsel_reg[`WSIC_LVLA_HI:`WSIC_LVLA_LO]);
	assign ovr.lvl[1]   = wsic_lvl_t'(lvlsel_reg[`WSIC_LVLB_HI:`WSIC_LVLB_LO]);
	assign ovr.pol[0]   = pol_reg[`WSIC_POLA_BIT];
	assign ovr.pol[1]   = pol_reg[`WSIC_POLB_BIT];
	assign ovr.wave[0]  = in_sel;
	assign ovr.wave[1]  = !in_sel;

	wsic_out_stage u_out (
		.core_clk (core_clk),
		.nrst     (nrst),
		.ovr      (ovr),
		.pin      (pin),
		.pin_oe   (pin_oe)
	);

	assign output_a    = pin[0];
	assign output_a_oe = pin_oe[0];
	assign output_b    = pin[1];
	assign output_b_oe = pin_oe[1];

	// ==========================================
	// Checks
	bit3_reads_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
		avs_read && !ack_reg && avs_address == `WSIC_OFS_LVLSEL |=> !avs_readdata[3])
		else $error("Bit 3 read as one");
	hold_until_edge_a: assert property (@(posedge core_clk) disable iff (!nrst)
		state_reg == WSIC_HOLD && !flag_reg && !in_rise |=> ovr.override)
		else $error("Override dropped before input edge");
	resume_on_edge_a: assert property (@(posedge core_clk) disable iff (!nrst)
		state_reg == WSIC_HOLD && !flag_reg && in_rise |=> !ovr.override)
		else $error("No resume on input edge");
	auto_restart_a: assert property (@(posedge core_clk) disable iff (!nrst)
		ars_reg && flag_reg && !src_hit |=> !flag_reg)
		else $error("Flag not auto cleared");
	flag_to_ovr_a: assert property (@(posedge core_clk) disable iff (!nrst)
		$rose(flag_reg) |=> ovr.override)
		else $error("Override late after flag");
	src_sel_a: assert property (@(posedge core_clk) disable iff (!nrst)
		lvlsel_reg[2:0] == 3'h7 && $stable(lvlsel_reg) |-> ovr.wave[0] == in_sync[7])
		else $error("Source select wrong");
	bus_answer_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(avs_read || avs_write) && !ack_reg |=> !avs_waitrequest)
		else $error("Bus answer late");
endmodule // wsic_shutdown_ctrl

/* verif/wsic_switch_model.sv */
// Model of the external power switches that load the two output pins
`timescale 1ns/1ps
module wsic_switch_model (
	// Pins from the device
	input  wire logic pin_a,
	input  wire logic oe_a,
	input  wire logic pin_b,
	input  wire logic oe_b,
	// Gate levels seen by the switches
	output logic      gate_a,
	output logic      gate_b
);
	// ==========================================
	// Gate pull-down keeps a released switch off
	assign gate_a = oe_a ? pin_a : 1'b0;
	assign gate_b = oe_b ? pin_b : 1'b0;
endmodule // wsic_switch_model

/* verif/tb_top.sv */
// Self-checking testbench for the shutdown override and input source block
`timescale 1ns/1ps
`include "wsic_consts.svh"
module tb_top;
	// ==========================================
	// Signals
	typedef struct packed {logic [7:0] lvl; logic [1:0] pol; logic [3:0] exp;} wsic_row_t;
	logic        core_clk        = 1'b0;
	logic        nrst            = 1'b0;
	logic [4:0]  avs_address     = 5'h00;
	logic        avs_read        = 1'b0;
	logic        avs_write       = 1'b0;
	logic [31:0] avs_writedata   = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  input_src       = 8'h00;
	logic [2:0]  shutdown_src    = 3'h0;
	logic        output_a;
	logic        output_a_oe;
	logic        output_b;
	logic        output_b_oe;
	logic        irq;
	logic        gate_a;
	logic        gate_b;
	logic [31:0] rd;
	int          failures        = 0;
	int          n_checks        = 0;
	// Level and select, polarity, expected {oe_b, b, oe_a, a} in shutdown
	wsic_row_t   rows [6]        = '{'{8'hf1, 2'h3, 4'hf}, '{8'ha1, 2'h3, 4'ha}, '{8'h51, 2'h0, 4'h0},
	                                 '{8'h01, 2'h1, 4'hb}, '{8'h61, 2'h1, 4'h2}, '{8'h31, 2'h2, 4'hf}};

	always #5 core_clk = ~core_clk;

	// ==========================================
	// Design and far side
	wsic_shutdown_ctrl wsic_shutdown_ctrl_inst (
		.core_clk        (core_clk),
		.nrst            (nrst),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (4'hf),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.input_src       (input_src),
		.shutdown_src    (shutdown_src),
		.output_a        (output_a),
		.output_a_oe     (output_a_oe),
		.output_b        (output_b),
		.output_b_oe     (output_b_oe),
		.irq             (irq)
	);
	wsic_switch_model wsic_switch_model_inst (
		.pin_a  (output_a),
		.oe_a   (output_a_oe),
		.pin_b  (output_b),
		.oe_b   (output_b_oe),
		.gate_a (gate_a),
		.gate_b (gate_b)
	);

	// ==========================================
	// Tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task cp(input logic [3:0] e);
		@(negedge core_clk);
		chk({28'h0, output_b_oe, gate_b, output_a_oe, gate_a}, {28'h0, e});
	endtask

	task ci(input logic e);
		@(negedge core_clk);
		chk({31'h0, irq}, {31'h0, e});
	endtask

	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= ~w;
		n = 0;
		// Request held until the rising edge that sees waitrequest low
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, avs_waitrequest, 1'b0);
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task done(input string s);
		$display("test %s done", s);
	endtask

	task finish_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ==========================================
	// Watchdog
	initial begin
		repeat (5000) @(posedge core_clk);
		failures++;
		finish_test;
	end

	// ==========================================
	// Main sequence
	initial begin
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		bus(1'b0, `WSIC_OFS_LVLSEL, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, `WSIC_OFS_LVLSEL, 32'hff);
		bus(1'b0, `WSIC_OFS_LVLSEL, 32'h0);
		chk(rd, 32'hf7);
		bus(1'b0, 5'h18, 32'h0);
		chk(rd, 32'h0);
		done("registers");
		foreach (rows[i]) begin
			bus(1'b1, `WSIC_OFS_LVLSEL, {24'h0, rows[i].lvl});
			bus(1'b1, `WSIC_OFS_CTRL, {30'h0, rows[i].pol});
			bus(1'b1, `WSIC_OFS_SHDN, 32'h80);
			repeat (4) @(posedge core_clk);
			cp(rows[i].exp);
			bus(1'b1, `WSIC_OFS_SHDN, 32'h0);
			repeat (4) @(posedge core_clk);
			cp(rows[i].exp);
			@(posedge core_clk);
			input_src <= 8'h02;
			repeat (6) @(posedge core_clk);
			cp({1'b1, rows[i].pol[1], 1'b1, ~rows[i].pol[0]});
			@(posedge core_clk);
			input_src <= 8'h00;
		end
		done("override levels");
		bus(1'b1, `WSIC_OFS_LVLSEL, 32'h01);
		bus(1'b1, `WSIC_OFS_CTRL, 32'h0);
		bus(1'b1, `WSIC_OFS_DBAND, 32'h08);
		@(posedge core_clk);
		input_src <= 8'h02;
		repeat (6) @(posedge core_clk);
		bus(1'b1, `WSIC_OFS_SHDN, 32'h80);
		repeat (3) @(posedge core_clk);
		cp(4'hb);
		repeat (12) @(posedge core_clk);
		cp(4'ha);
		bus(1'b1, `WSIC_OFS_SHDN, 32'h0);
		@(posedge core_clk);
		input_src <= 8'h00;
		repeat (4) @(posedge core_clk);
		cp(4'ha);
		@(posedge core_clk);
		input_src <= 8'h02;
		repeat (6) @(posedge core_clk);
		cp(4'hb);
		bus(1'b0, `WSIC_OFS_IRQ_STAT, 32'h0);
		chk(rd, 32'h3);
		done("dead band");
		for (int k = 0; k < 8; k++) begin
			bus(1'b1, `WSIC_OFS_LVLSEL, k);
			@(posedge core_clk);
			input_src <= 8'h01 << k;
			repeat (6) @(posedge core_clk);
			cp({1'b1, k == 0, 1'b1, k != 0});
			@(posedge core_clk);
			input_src <= ~(8'h01 << k);
			repeat (6) @(posedge core_clk);
			cp(4'he);
		end
		done("input select");
		bus(1'b1, `WSIC_OFS_IRQ_STAT, 32'h3);
		bus(1'b1, `WSIC_OFS_IRQ_MASK, 32'h1);
		bus(1'b1, `WSIC_OFS_SHDN, 32'h41);
		@(posedge core_clk);
		shutdown_src <= 3'h1;
		repeat (6) @(posedge core_clk);
		ci(1'b1);
		bus(1'b1, `WSIC_OFS_SHDN, 32'h41);
		bus(1'b0, `WSIC_OFS_SHDN, 32'h0);
		chk(rd, 32'hc1);
		bus(1'b1, `WSIC_OFS_IRQ_MASK, 32'h0);
		ci(1'b0);
		@(posedge core_clk);
		shutdown_src <= 3'h0;
		repeat (6) @(posedge core_clk);
		bus(1'b0, `WSIC_OFS_SHDN, 32'h0);
		chk(rd, 32'h41);
		bus(1'b1, `WSIC_OFS_IRQ_STAT, 32'h1);
		bus(1'b1, `WSIC_OFS_IRQ_MASK, 32'h1);
		ci(1'b0);
		done("auto restart");
		@(posedge core_clk);
		nrst <= 1'b0;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		bus(1'b0, `WSIC_OFS_LVLSEL, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, `WSIC_OFS_DBAND, 32'h0);
		chk(rd, 32'h0);
		cp(4'he);
		ci(1'b0);
		done("second reset");
		finish_test;
	end
endmodule // tb_top
